/* File: include/trig_result_map.vh */
`ifndef TRIG_RESULT_MAP_VH
`define TRIG_RESULT_MAP_VH
// Register byte offsets.
`define OFS_TRIG1_CFG 8'h00
`define OFS_TRIG2_CFG 8'h04
`define OFS_OUT_CFG 8'h08
`define OFS_PULSE_MS 8'h0C
`define OFS_EVENTS 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_STATUS 8'h1C
`define OFS_FLASH_US 8'h20
// Second trigger roles.
`define ROLE_NONE 2'h0
`define ROLE_PATH_TICK 2'h1
`define ROLE_TEACH 2'h2
`define ROLE_END 2'h3
// Result output functions.
`define FN_OFF 3'h0
`define FN_READY 3'h1
`define FN_GOOD 3'h2
`define FN_NOREAD 3'h3
`define FN_MATCH 3'h4
`define FN_FLASH 3'h5
// Flash behaviours for the first output.
`define FLASH_PULSE 1'b0
`define FLASH_STATIC 1'b1
// Reset values.
`define RST_TRIG1_CFG 32'h0000_000A
`define RST_TRIG2_CFG 32'h0000_0A00
`define RST_OUT_CFG 32'h0000_0021
`define RST_PULSE_MS 16'h0064
`define RST_FLASH_US 16'h03E8
// Timing.
`define CLK_HZ 25000000
`define US_PER_S 1000000
`define MS_PER_S 1000
`endif

/* File: design/ms_tick_gen.v */
`timescale 1ns/100ps
`include "trig_result_map.vh"
// Divides the system clock down to millisecond and microsecond ticks.
module ms_tick_gen #(
  parameter CLK_HZ = `CLK_HZ
) (
  input wire clk,
  input wire rst_b,
  output reg us_tick,
  output reg ms_tick
);
  // Below one clock per microsecond the microsecond tick fires on every clock.
  localparam US_RAW = CLK_HZ / `US_PER_S;
  localparam US_CYC = (US_RAW > 0) ? US_RAW : 1;
  // The millisecond count is kept apart so slow clocks still give exact milliseconds.
  // Clocks above about 65 MHz would overflow this 16-bit count.
  localparam MS_CYC = CLK_HZ / `MS_PER_S;
  reg [15:0] us_cnt_r;
  reg [15:0] ms_cnt_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      us_cnt_r <= 16'h0000;
      ms_cnt_r <= 16'h0000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
      if (us_cnt_r == US_CYC[15:0] - 16'h0001) begin
        us_cnt_r <= 16'h0000;
        us_tick <= 1'b1;
      end else begin
        us_cnt_r <= us_cnt_r + 16'h0001;
      end
      if (ms_cnt_r == MS_CYC[15:0] - 16'h0001) begin
        ms_cnt_r <= 16'h0000;
        ms_tick <= 1'b1;
      end else begin
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      end
    end
  end
endmodule // ms_tick_gen

/* File: design/reader_trigger_result_io.v */
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "trig_result_map.vh"
module reader_trigger_result_io #(
  parameter CLK_HZ = `CLK_HZ
) (
  input wire clk,
  input wire rst_b,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire trig1_pin,
  input wire trig2_pin,
  input wire reading_op,
  input wire ev_good,
  input wire ev_noread,
  input wire ev_match,
  input wire flash_req,
  output reg result1_pin,
  output reg result2_pin,
  output reg result_lamp,
  output reg interval_active,
  output reg path_tick,
  output reg teach_pulse,
  output reg irq
);
  // Trigger config: [7:0] debounce ms, [8] invert, [23:16] start delay ms or path ticks, [31:24] stop delay ms.
  // Trigger two config: [7:0] debounce ms, [8] invert, [13:12] role, [31:24] stop delay ms.
  // Output config: [2:0] fn1, [3] inv1, [6:4] fn2, [7] inv2, [8] flash behaviour.
  reg [31:0] trig1_cfg_r;
  reg [31:0] trig2_cfg_r;
  reg [31:0] out_cfg_r;
  reg [15:0] pulse_ms_r;
  reg [15:0] flash_us_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [2:0] events_r;
  wire us_tick;
  wire ms_tick;
  ms_tick_gen #(.CLK_HZ(CLK_HZ)) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );
  // Pin synchronisers: a change counts once stages two and three agree.
  reg [2:0] t1_sync_r;
  reg [2:0] t2_sync_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_sync_r <= 3'h0;
      t2_sync_r <= 3'h0;
    end else begin
      t1_sync_r <= {t1_sync_r[1:0], trig1_pin};
      t2_sync_r <= {t2_sync_r[1:0], trig2_pin};
    end
  end
  // Debounce: a new level must hold for the configured milliseconds.
  reg t1_lvl_r;
  reg t2_lvl_r;
  reg [7:0] t1_db_r;
  reg [7:0] t2_db_r;
  wire t1_agree = (t1_sync_r[1] == t1_sync_r[2]);
  wire t2_agree = (t2_sync_r[1] == t2_sync_r[2]);
  wire t1_act = t1_sync_r[2] ^ trig1_cfg_r[8];
  wire t2_act = t2_sync_r[2] ^ trig2_cfg_r[8];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_lvl_r <= 1'b0;
      t2_lvl_r <= 1'b0;
      t1_db_r <= 8'h00;
      t2_db_r <= 8'h00;
    end else begin
      if (!t1_agree || t1_act == t1_lvl_r) begin
        t1_db_r <= 8'h00;
      end else if (t1_db_r >= trig1_cfg_r[7:0]) begin
        t1_lvl_r <= t1_act;
        t1_db_r <= 8'h00;
      end else if (ms_tick) begin
        t1_db_r <= t1_db_r + 8'h01;
      end
      if (!t2_agree || t2_act == t2_lvl_r) begin
        t2_db_r <= 8'h00;
      end else if (t2_db_r >= trig2_cfg_r[7:0]) begin
        t2_lvl_r <= t2_act;
        t2_db_r <= 8'h00;
      end else if (ms_tick) begin
        t2_db_r <= t2_db_r + 8'h01;
      end
    end
  end
  reg t1_prev_r;
  reg t2_prev_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_prev_r <= 1'b0;
      t2_prev_r <= 1'b0;
    end else begin
      t1_prev_r <= t1_lvl_r;
      t2_prev_r <= t2_lvl_r;
    end
  end
  wire t1_rise = t1_lvl_r & ~t1_prev_r;
  wire t1_fall = ~t1_lvl_r & t1_prev_r;
  wire t2_rise = t2_lvl_r & ~t2_prev_r;
  wire [1:0] role = trig2_cfg_r[13:12];
  // Reading interval state machine with start and stop delays.
  localparam ST_IDLE = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_OPEN = 2'h2;
  localparam ST_STOP = 2'h3;
  reg [1:0] state_r;
  reg [7:0] dly_r;
  reg [7:0] stop_lim_r;
  reg end_pulse_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      dly_r <= 8'h00;
      stop_lim_r <= 8'h00;
      end_pulse_r <= 1'b0;
      interval_active <= 1'b0;
      path_tick <= 1'b0;
      teach_pulse <= 1'b0;
    end else begin
      end_pulse_r <= 1'b0;
      path_tick <= (role == `ROLE_PATH_TICK) & t2_rise;
      teach_pulse <= (role == `ROLE_TEACH) & t2_rise;
      case (state_r)
        ST_IDLE: begin
          dly_r <= 8'h00;
          if (t1_rise) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          // Start delay counts path ticks when that role is chosen, else milliseconds.
          if (dly_r >= trig1_cfg_r[23:16]) begin
            state_r <= ST_OPEN;
            interval_active <= 1'b1;
          end else if ((role == `ROLE_PATH_TICK) ? t2_rise : ms_tick) begin
            dly_r <= dly_r + 8'h01;
          end
        end
        ST_OPEN: begin
          dly_r <= 8'h00;
          if ((role == `ROLE_END) && t2_rise) begin
            state_r <= ST_STOP;
            stop_lim_r <= trig2_cfg_r[31:24];
          end else if (t1_fall) begin
            state_r <= ST_STOP;
            stop_lim_r <= trig1_cfg_r[31:24];
          end
        end
        default: begin
          if (dly_r >= stop_lim_r) begin
            state_r <= ST_IDLE;
            interval_active <= 1'b0;
            end_pulse_r <= 1'b1;
          end else if (ms_tick) begin
            dly_r <= dly_r + 8'h01;
          end
        end
      endcase
    end
  end
  wire open_pulse = (state_r == ST_START) && (dly_r >= trig1_cfg_r[23:16]);
  // Event flags per interval; a new interval clears them first.
  wire [2:0] ev_in = {ev_match, ev_noread, ev_good};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      events_r <= 3'h0;
    end else if (open_pulse) begin
      events_r <= 3'h0;
    end else if (interval_active) begin
      events_r <= events_r | ev_in;
    end
  end
  // Result outputs, one per generate entry.
  wire [1:0] out_raw;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_out
      wire [2:0] fn = out_cfg_r[4*g+2:4*g];
      wire flash = (g == 0) && (fn == `FN_FLASH);
      reg [15:0] cnt_r;
      reg on_r;
      reg hit;
      always @* begin
        hit = 1'b0;
        case (fn)
          `FN_GOOD: hit = events_r[0];
          `FN_NOREAD: hit = events_r[1];
          `FN_MATCH: hit = events_r[2];
          default: hit = 1'b0;
        endcase
      end
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_r <= 16'h0000;
          on_r <= 1'b0;
        end else if (flash) begin
          // Flash timing runs in microseconds so short lamp pulses stay precise.
          if (out_cfg_r[8] == `FLASH_STATIC) begin
            on_r <= interval_active;
          end else if (flash_req) begin
            on_r <= 1'b1;
            cnt_r <= flash_us_r;
          end else if (on_r && us_tick) begin
            if (cnt_r <= 16'h0001) begin
              on_r <= 1'b0;
            end
            cnt_r <= cnt_r - 16'h0001;
          end
        end else if (fn == `FN_READY) begin
          on_r <= reading_op;
        end else if (end_pulse_r && hit) begin
          on_r <= (pulse_ms_r != 16'h0000);
          cnt_r <= pulse_ms_r;
        end else if (on_r && ms_tick) begin
          if (cnt_r <= 16'h0001) begin
            on_r <= 1'b0;
          end
          cnt_r <= cnt_r - 16'h0001;
        end else if (!on_r) begin
          cnt_r <= 16'h0000;
        end
      end
      assign out_raw[g] = on_r ^ out_cfg_r[4*g+3];
    end
  endgenerate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result1_pin <= 1'b0;
      result2_pin <= 1'b0;
      result_lamp <= 1'b0;
      irq <= 1'b0;
    end else begin
      result1_pin <= out_raw[0];
      result2_pin <= out_raw[1];
      result_lamp <= g_out[1].on_r & reading_op;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
  // Wishbone slave: ack one cycle after the strobe, dropped the cycle after.
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] adr = wb_adr_i[7:0];
  // Status events: bit0 interval end, bit1 teach trigger, bit2 interval open.
  wire [2:0] irq_set = {open_pulse, (role == `ROLE_TEACH) & t2_rise, end_pulse_r};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig1_cfg_r <= `RST_TRIG1_CFG;
      trig2_cfg_r <= `RST_TRIG2_CFG;
      out_cfg_r <= `RST_OUT_CFG;
      pulse_ms_r <= `RST_PULSE_MS;
      flash_us_r <= `RST_FLASH_US;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (wr && adr == `OFS_TRIG1_CFG) begin
        trig1_cfg_r <= wb_dat_i;
      end else if (wr && adr == `OFS_TRIG2_CFG) begin
        trig2_cfg_r <= wb_dat_i;
      end else if (wr && adr == `OFS_OUT_CFG) begin
        out_cfg_r <= wb_dat_i;
      end else if (wr && adr == `OFS_PULSE_MS) begin
        pulse_ms_r <= wb_dat_i[15:0];
      end else if (wr && adr == `OFS_FLASH_US) begin
        flash_us_r <= wb_dat_i[15:0];
      end else if (wr && adr == `OFS_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[2:0];
      end
      // A set in the same cycle as a clear wins.
      if (wr && adr == `OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[2:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (adr == `OFS_TRIG1_CFG) begin
          wb_dat_o <= trig1_cfg_r;
        end else if (adr == `OFS_TRIG2_CFG) begin
          wb_dat_o <= trig2_cfg_r;
        end else if (adr == `OFS_OUT_CFG) begin
          wb_dat_o <= out_cfg_r;
        end else if (adr == `OFS_PULSE_MS) begin
          wb_dat_o <= {16'h0000, pulse_ms_r};
        end else if (adr == `OFS_FLASH_US) begin
          wb_dat_o <= {16'h0000, flash_us_r};
        end else if (adr == `OFS_EVENTS) begin
          wb_dat_o <= {29'h0000_0000, events_r};
        end else if (adr == `OFS_IRQ_STAT) begin
          wb_dat_o <= {29'h0000_0000, irq_stat_r};
        end else if (adr == `OFS_IRQ_MASK) begin
          wb_dat_o <= {29'h0000_0000, irq_mask_r};
        end else if (adr == `OFS_STATUS) begin
          wb_dat_o <= {26'h000_0000, state_r, t2_lvl_r, t1_lvl_r, result2_pin, result1_pin};
        end
      end
    end
  end
endmodule // reader_trigger_result_io

/* File: testbench/io_asserts.sv */
`timescale 1ns/100ps
module io_asserts (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire reading_op,
  input wire result2_pin,
  input wire result_lamp,
  input wire interval_active,
  input wire path_tick,
  input wire teach_pulse,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_dat_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data without ack");
  a_path_pulse: assert property (
    path_tick |=> !path_tick) else $error("path tick too long");
  a_teach_pulse: assert property (
    teach_pulse |=> !teach_pulse) else $error("teach pulse too long");
  a_role_excl: assert property (
    !(path_tick && teach_pulse)) else $error("two roles at once");
  // The lamp is gated by reading operation, so two idle cycles must leave it dark.
  a_lamp_needs_op: assert property (
    !reading_op ##1 !reading_op |-> !result_lamp) else $error("lamp outside reading");
  a_result_after_end: assert property (
    $rose(result2_pin) |-> !$past(interval_active)) else $error("result inside interval");
  a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |-> !result2_pin && !irq && !interval_active) else $error("output in reset");
endmodule // io_asserts

/* File: testbench/field_model.sv */
`timescale 1ns/100ps
// Sensors on the trigger pins and a controller input timing the second output.
module field_model (
  input wire clk,
  input wire t1_req,
  input wire t2_req,
  input wire result2_pin,
  output reg trig1_pin,
  output reg trig2_pin,
  output reg [15:0] pulse_len
);
  reg [15:0] cnt_r;
  initial begin
    trig1_pin = 1'b0;
    trig2_pin = 1'b0;
    pulse_len = 16'h0000;
    cnt_r = 16'h0000;
  end
  // Pins switch just after an edge, as a real sensor is unrelated to sampling.
  always @(posedge clk) begin
    trig1_pin <= t1_req;
    trig2_pin <= t2_req;
    if (result2_pin)
      cnt_r <= cnt_r + 16'h0001;
    else if (cnt_r != 16'h0000) begin
      pulse_len <= cnt_r;
      cnt_r <= 16'h0000;
    end
  end
endmodule // field_model

/* File: testbench/reader_trigger_result_io_tb.sv */
`timescale 1ns/100ps
module reader_trigger_result_io_tb;
  reg clk = 1'b0, rst_b, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  reg [3:0] sel = 4'hf;
  reg [31:0] adr = 32'h0000_0000, wdat = 32'h0000_0000, q;
  reg op = 1'b0, good = 1'b0, nrd = 1'b0, t1 = 1'b0, t2 = 1'b0, fl = 1'b0, mt = 1'b0;
  wire [31:0] rdat;
  wire ack, r1, r2, lamp, act, ptk, tch, irq, p1, p2;
  wire [15:0] len;
  wire [3:0] mon = {irq, r1, r2, act};
  integer bad_count = 0, n_tests = 0, cyc_n = 0, i, k, np, nt;
  reg [39:0] rows [0:6];
  initial forever #20 clk = ~clk;
  // 1 ms becomes 25 cycles so that debounce and pulse times stay short.
  reader_trigger_result_io #(.CLK_HZ(25000)) reader_trigger_result_io_inst (.clk(clk),
    .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .trig1_pin(p1),
    .trig2_pin(p2), .reading_op(op), .ev_good(good), .ev_noread(nrd), .ev_match(mt),
    .flash_req(fl), .result1_pin(r1), .result2_pin(r2), .result_lamp(lamp),
    .interval_active(act), .path_tick(ptk), .teach_pulse(tch), .irq(irq));
  field_model field_model_inst (.clk(clk), .t1_req(t1), .t2_req(t2), .result2_pin(r2),
    .trig1_pin(p1), .trig2_pin(p2), .pulse_len(len));
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h00_0000, a};
      wdat <= d;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task wt(input integer s, input v);
    begin
      k = 0;
      while (mon[s] !== v && k < 3000) begin
        @(posedge clk);
        k = k + 1;
      end
      chk(32'(mon[s]), 32'(v));
    end
  endtask
  task conclude;
    begin
      $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      bad_count = bad_count + 1;
      conclude;
    end
  end
  initial begin
    rst_b <= 1'b0;
    rows[0] = {8'h00, 32'h0000_000A};
    rows[1] = {8'h04, 32'h0000_0A00};
    rows[2] = {8'h08, 32'h0000_0021};
    rows[3] = {8'h0C, 32'h0000_0064};
    rows[4] = {8'h20, 32'h0000_03E8};
    rows[5] = {8'h24, 32'h0000_0000};
    rows[6] = {8'h10, 32'h0000_0000};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      wb(rows[i][39:32], 1'b0, 32'h0000_0000);
      chk(q, rows[i][31:0]);
    end
    $display("reset values done");
    op <= 1'b1;
    wt(2, 1'b1);
    op <= 1'b0;
    wt(2, 1'b0);
    op <= 1'b1;
    $display("ready output done");
    wb(8'h08, 1'b1, 32'h0000_002B);
    wb(8'h0C, 1'b1, 32'h0000_0002);
    wb(8'h18, 1'b1, 32'h0000_0001);
    wt(2, 1'b1);
    t1 <= 1'b1;
    wt(0, 1'b1);
    good <= 1'b1;
    @(posedge clk);
    good <= 1'b0;
    wb(8'h10, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    t1 <= 1'b0;
    wt(0, 1'b0);
    wt(1, 1'b1);
    repeat (3) @(posedge clk);
    chk(32'(lamp), 32'h1);
    chk(32'(r1), 32'h1);
    wt(1, 1'b0);
    @(posedge clk);
    chk(32'(len >= 16'd25 && len <= 16'd52), 32'h1);
    chk(32'(irq), 32'h1);
    wb(8'h14, 1'b1, 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    $display("good read interval done");
    t1 <= 1'b1;
    wt(0, 1'b1);
    wb(8'h10, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    nrd <= 1'b1;
    @(posedge clk);
    nrd <= 1'b0;
    t1 <= 1'b0;
    wt(0, 1'b0);
    wt(2, 1'b0);
    chk(32'(r2), 32'h0);
    wt(2, 1'b1);
    $display("no-read interval done");
    for (i = 0; i < 4; i = i + 1) begin
      wb(8'h04, 1'b1, 32'(i) << 12);
      if (i == 3) begin
        t1 <= 1'b1;
        wt(0, 1'b1);
      end
      np = 0;
      nt = 0;
      t2 <= 1'b1;
      repeat (80) begin
        @(posedge clk);
        np = np + ptk;
        nt = nt + tch;
      end
      chk(np, 32'(i == 1));
      chk(nt, 32'(i == 2));
      chk(32'(act), 32'h0);
      t2 <= 1'b0;
      t1 <= 1'b0;
      repeat (300) @(posedge clk);
    end
    $display("second trigger roles done");
    wb(8'h20, 1'b1, 32'h0000_0010);
    wb(8'h08, 1'b1, 32'h0000_0045);
    fl <= 1'b1;
    @(posedge clk);
    fl <= 1'b0;
    wt(2, 1'b1);
    repeat (8) @(posedge clk);
    chk(32'(r1), 32'h1);
    wt(2, 1'b0);
    wb(8'h08, 1'b1, 32'h0000_0145);
    t1 <= 1'b1;
    wt(2, 1'b1);
    mt <= 1'b1;
    @(posedge clk);
    mt <= 1'b0;
    t1 <= 1'b0;
    wt(2, 1'b0);
    wt(1, 1'b1);
    $display("flash and match done");
    rst_b <= 1'b0;
    @(posedge clk);
    chk(32'(mon), 32'h0);
    rst_b <= 1'b1;
    wb(8'h08, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0021);
    wb(8'h04, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0A00);
    $display("mid-run reset done");
    conclude;
  end
endmodule // reader_trigger_result_io_tb
bind reader_trigger_result_io io_asserts io_asserts_inst (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .reading_op(reading_op), .result2_pin(result2_pin), .result_lamp(result_lamp),
  .interval_active(interval_active), .path_tick(path_tick), .teach_pulse(teach_pulse),
  .irq(irq));
